// File: hdl/sspd_pkg.sv
package sspd_pkg;

  localparam int          WORD_W          = 24;
  localparam int          B_W             = 13;
  localparam int          A_W             = 5;
  localparam int          R_W             = 14;

  // target select codes in the two low bits of a word
  localparam logic [1:0]  SEL_CONTROL     = 2'h0;
  localparam logic [1:0]  SEL_REFCNT      = 2'h1;
  localparam logic [1:0]  SEL_FBCNT       = 2'h2;
  localparam logic [1:0]  SEL_TEST        = 2'h3;

  // control latch fields
  localparam int          CTL_PRESC_LSB   = 22;
  localparam int          CTL_LEVEL_LSB   = 12;
  localparam int          CTL_MUTE_BIT    = 11;
  localparam int          CTL_CPTRI_BIT   = 9;
  localparam int          CTL_MON_LSB     = 5;
  localparam int          CTL_CRST_BIT    = 4;

  // feedback counter latch fields
  localparam int          FB_HALVE_BIT    = 22;
  localparam int          FB_B_LSB        = 8;
  localparam int          FB_A_LSB        = 2;

  // reference counter latch fields
  localparam int          REF_BANDDIV_LSB = 20;
  localparam int          REF_LOCKCNT_BIT = 18;
  localparam int          REF_BKLASH_LSB  = 16;
  localparam int          REF_R_LSB       = 2;

  localparam logic [23:0] LATCH_RESET     = 24'h000000;

  // prescaler modulus codes
  localparam logic [1:0]  PRESC_8_9       = 2'h0;
  localparam logic [1:0]  PRESC_16_17     = 2'h1;
  localparam logic [1:0]  PRESC_32_33     = 2'h2;

  // monitor output selections
  localparam logic [2:0]  MON_TRISTATE    = 3'h0;
  localparam logic [2:0]  MON_DIGITAL_LD  = 3'h1;
  localparam logic [2:0]  MON_FB_DIV      = 3'h2;
  localparam logic [2:0]  MON_HIGH        = 3'h3;
  localparam logic [2:0]  MON_REF_DIV     = 3'h4;
  localparam logic [2:0]  MON_ANALOG_LD   = 3'h5;
  localparam logic [2:0]  MON_SER_DATA    = 3'h6;
  localparam logic [2:0]  MON_LOW         = 3'h7;

  // timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          LOCK_GOOD_NS    = 15;
  localparam int          LOCK_BAD_NS     = 25;
  // error below LOCK_GOOD_CYC clock cycles is good, at or above LOCK_BAD_CYC is bad
  localparam int          LOCK_GOOD_CYC   = (LOCK_GOOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LOCK_BAD_CYC    = LOCK_BAD_NS / CLK_PERIOD_NS + 1;
  localparam logic [2:0]  LOCK_RUN_SHORT  = 3'h3;
  localparam logic [2:0]  LOCK_RUN_LONG   = 3'h5;
  localparam logic [2:0]  BAND_SEL_CYCLES = 3'h5;

  typedef enum logic [1:0] {
    BS_IDLE = 2'b01,
    BS_RUN  = 2'b10
  } sspd_band_t;

  typedef enum logic [2:0] {
    PH_IDLE     = 3'b001,
    PH_REFFIRST = 3'b010,
    PH_FBFIRST  = 3'b100
  } sspd_phase_t;

  function automatic logic sspdRise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

endpackage

// File: hdl/sspd_lock_detect.sv
`timescale 1ns/100ps
module sspd_lock_detect
  import sspd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic refPulse,
  input  wire logic fbPulse,
  input  wire logic lockCountLong,
  output logic      lockDetect,
  output logic      phaseWindow
);

  sspd_phase_t phase_reg;
  sspd_phase_t phase_next;
  logic [2:0]  errCnt_reg;
  logic [2:0]  errCnt_next;
  logic [2:0]  goodRun_reg;
  logic [2:0]  goodRun_next;
  logic        lock_reg;
  logic        lock_next;
  logic        window_reg;
  logic        window_next;
  logic        evalNow;
  logic [2:0]  evalErr;
  logic        evalGood;
  logic        evalBad;
  logic [2:0]  runNeeded;

  always_comb
  begin
    phase_next  = phase_reg;
    errCnt_next = (errCnt_reg == 3'h7) ? errCnt_reg : errCnt_reg + 3'h1;
    evalNow     = 1'b0;
    evalErr     = errCnt_reg;
    case (phase_reg)
      PH_IDLE:
      begin
        errCnt_next = 3'h1;
        if (refPulse && fbPulse)
        begin
          evalNow = 1'b1;
          evalErr = 3'h0;
        end
        else if (refPulse)
          phase_next = PH_REFFIRST;
        else if (fbPulse)
          phase_next = PH_FBFIRST;
      end
      PH_REFFIRST:
      begin
        // a second reference edge before feedback counts as a bad cycle
        if (fbPulse || refPulse)
        begin
          evalNow    = 1'b1;
          evalErr    = fbPulse ? errCnt_reg : 3'h7;
          phase_next = fbPulse ? PH_IDLE : PH_REFFIRST;
          errCnt_next = fbPulse ? errCnt_next : 3'h1;
        end
      end
      PH_FBFIRST:
      begin
        if (refPulse || fbPulse)
        begin
          evalNow    = 1'b1;
          evalErr    = refPulse ? errCnt_reg : 3'h7;
          phase_next = refPulse ? PH_IDLE : PH_FBFIRST;
          errCnt_next = refPulse ? errCnt_next : 3'h1;
        end
      end
      default:
        phase_next = PH_IDLE;
    endcase
    window_next = (phase_next != PH_IDLE);
  end

  always_comb
  begin
    runNeeded    = lockCountLong ? LOCK_RUN_LONG : LOCK_RUN_SHORT;
    evalGood     = evalNow && (evalErr < 3'(LOCK_GOOD_CYC));
    evalBad      = evalNow && (evalErr >= 3'(LOCK_BAD_CYC));
    goodRun_next = goodRun_reg;
    lock_next    = lock_reg;
    if (evalGood)
    begin
      goodRun_next = (goodRun_reg == 3'h7) ? goodRun_reg : goodRun_reg + 3'h1;
      if (goodRun_next >= runNeeded)
        lock_next = 1'b1;
    end
    else if (evalNow)
      goodRun_next = 3'h0;
    if (evalBad)
      lock_next = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg   <= PH_IDLE;
      errCnt_reg  <= 3'h0;
      goodRun_reg <= 3'h0;
      lock_reg    <= 1'b0;
      window_reg  <= 1'b0;
    end
    else
    begin
      phase_reg   <= phase_next;
      errCnt_reg  <= errCnt_next;
      goodRun_reg <= goodRun_next;
      lock_reg    <= lock_next;
      window_reg  <= window_next;
    end
  end

  assign lockDetect  = lock_reg;
  assign phaseWindow = window_reg;

  lock_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(lock_reg) |-> $past(evalGood) && ($past(goodRun_reg) >= 3'h2))
    else $error("lock rose without enough good cycles");

  lock_long_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($rose(lock_reg) && $past(lockCountLong)) |-> ($past(goodRun_reg) >= 3'h4))
    else $error("long lock count rose too early");

  lock_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (evalBad |=> !lock_reg) and ($fell(lock_reg) |-> $past(evalBad)))
    else $error("lock not cleared by bad phase error only");

endmodule // sspd_lock_detect

// File: hdl/sspd_synth_core.sv
`timescale 1ns/100ps
module sspd_synth_core
  import sspd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       serClk,
  input  wire logic       serData,
  input  wire logic       latchStrobe,
  input  wire logic       refIn,
  input  wire logic       fbIn,
  input  wire logic       chipEnable,
  output logic            monitorOut,
  output logic            monitorOe,
  output logic            digitalLock,
  output logic [1:0]      prescalerSel,
  output logic            modulusCtrl,
  output logic            halveOutput,
  output logic            chargePumpOe,
  output logic            tuneIsolate,
  output logic            rfStageEnable,
  output logic            powerDown,
  output logic [1:0]      antibacklashWidth,
  output logic [1:0]      outputLevel
);

  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [WORD_W-1:0] ctl_reg;
  logic [WORD_W-1:0] ctl_next;
  logic [WORD_W-1:0] refLatch_reg;
  logic [WORD_W-1:0] refLatch_next;
  logic [WORD_W-1:0] fbLatch_reg;
  logic [WORD_W-1:0] fbLatch_next;
  // previous samples of serial clock, strobe, reference and feedback
  logic [3:0]        inPrev_reg;
  logic              serEdge;
  logic              strobeEdge;
  logic              refEdge;
  logic              fbEdge;
  logic              fbWrite;

  always_comb
  begin
    serEdge       = sspdRise(inPrev_reg[3], serClk);
    strobeEdge    = sspdRise(inPrev_reg[2], latchStrobe);
    refEdge       = sspdRise(inPrev_reg[1], refIn);
    fbEdge        = sspdRise(inPrev_reg[0], fbIn);
    shift_next    = serEdge ? {shift_reg[WORD_W-2:0], serData} : shift_reg;
    ctl_next      = ctl_reg;
    refLatch_next = refLatch_reg;
    fbLatch_next  = fbLatch_reg;
    fbWrite       = 1'b0;
    // the word in place before this cycle's shift is the one latched
    if (strobeEdge)
    begin
      if (shift_reg[1:0] == SEL_CONTROL)
        ctl_next = shift_reg;
      else if (shift_reg[1:0] == SEL_REFCNT)
        refLatch_next = shift_reg;
      else if (shift_reg[1:0] == SEL_FBCNT)
      begin
        fbLatch_next = shift_reg;
        fbWrite      = 1'b1;
      end
      // factory test code: no latch is built, the word is dropped
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_reg      <= LATCH_RESET;
      ctl_reg        <= LATCH_RESET;
      refLatch_reg   <= LATCH_RESET;
      fbLatch_reg    <= LATCH_RESET;
      inPrev_reg     <= 4'h0;
    end
    else
    begin
      shift_reg      <= shift_next;
      ctl_reg        <= ctl_next;
      refLatch_reg   <= refLatch_next;
      fbLatch_reg    <= fbLatch_next;
      inPrev_reg     <= {serClk, latchStrobe, refIn, fbIn};
    end
  end

  // field views
  wire logic [B_W-1:0] bRatio      = fbLatch_reg[FB_B_LSB +: B_W];
  wire logic [A_W-1:0] aSwallow    = fbLatch_reg[FB_A_LSB +: A_W];
  wire logic [R_W-1:0] rRatio      = refLatch_reg[REF_R_LSB +: R_W];
  wire logic [1:0]     bandDivSel  = refLatch_reg[REF_BANDDIV_LSB +: 2];
  wire logic           counterHold = ctl_reg[CTL_CRST_BIT] | ~chipEnable;

  // dividers and band select
  sspd_band_t     band_reg;
  sspd_band_t     band_next;
  logic [2:0]     bandCnt_reg;
  logic [2:0]     bandCnt_next;
  logic [2:0]     preDiv_reg;
  logic [2:0]     preDiv_next;
  logic [R_W-1:0] rCount_reg;
  logic [R_W-1:0] rCount_next;
  logic [B_W-1:0] bCount_reg;
  logic [B_W-1:0] bCount_next;
  logic           refPulse_reg;
  logic           refPulse_next;
  logic           fbPulse_reg;
  logic           fbPulse_next;
  logic           modulus_reg;
  logic           modulus_next;
  logic           rTick;
  logic [2:0]     preDivLast;

  always_comb
  begin
    // the extra divider only sits in front of the R counter during band select
    preDivLast    = 3'((4'h1 << bandDivSel) - 4'h1);
    rTick         = refEdge && (band_reg != BS_RUN || preDiv_reg == preDivLast);
    preDiv_next   = (band_reg != BS_RUN || rTick) ? 3'h0 : preDiv_reg + {2'h0, refEdge};
    // ratio 0 behaves as 1
    refPulse_next = rTick && !counterHold
                    && ({1'b0, rCount_reg} + 15'h1 >= {1'b0, rRatio});
    rCount_next   = (counterHold || refPulse_next) ? '0 : rCount_reg + {13'h0, rTick};
    fbPulse_next  = fbEdge && !counterHold && !fbWrite
                    && ({1'b0, bCount_reg} + 14'h1 >= {1'b0, bRatio});
    bCount_next   = (counterHold || fbWrite || fbPulse_next) ? '0 : bCount_reg + {12'h0, fbEdge};
    // P+1 for the first A prescaler periods, then P: N = B*P + A
    modulus_next = ~counterHold && ({8'h00, aSwallow} > bCount_next);
  end

  always_comb
  begin
    band_next    = band_reg;
    bandCnt_next = bandCnt_reg;
    case (band_reg)
      BS_IDLE:
        if (fbWrite)
        begin
          band_next    = BS_RUN;
          bandCnt_next = 3'h0;
        end
      BS_RUN:
        if (fbWrite)
          bandCnt_next = 3'h0;
        else if (refPulse_next)
        begin
          bandCnt_next = bandCnt_reg + 3'h1;
          if (bandCnt_reg == BAND_SEL_CYCLES - 3'h1)
            band_next = BS_IDLE;
        end
      default:
        band_next = BS_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      band_reg     <= BS_RUN;
      bandCnt_reg  <= 3'h0;
      preDiv_reg   <= 3'h0;
      rCount_reg   <= '0;
      bCount_reg   <= '0;
      refPulse_reg <= 1'b0;
      fbPulse_reg  <= 1'b0;
      modulus_reg  <= 1'b0;
    end
    else
    begin
      band_reg     <= band_next;
      bandCnt_reg  <= bandCnt_next;
      preDiv_reg   <= preDiv_next;
      rCount_reg   <= rCount_next;
      bCount_reg   <= bCount_next;
      refPulse_reg <= refPulse_next;
      fbPulse_reg  <= fbPulse_next;
      modulus_reg  <= modulus_next;
    end
  end

  logic lockInt;
  logic phaseWindow;

  sspd_lock_detect u_lock (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .refPulse      (refPulse_reg),
    .fbPulse       (fbPulse_reg),
    .lockCountLong (refLatch_reg[REF_LOCKCNT_BIT]),
    .lockDetect    (lockInt),
    .phaseWindow   (phaseWindow)
  );

  // output stage
  logic       monOut_reg;
  logic       monOut_next;
  logic       monOe_reg;
  logic       monOe_next;
  logic       cpOe_reg;
  logic       cpOe_next;
  logic       isolate_reg;
  logic       isolate_next;
  logic       rfEn_reg;
  logic       rfEn_next;
  logic       pd_reg;
  logic       pd_next;
  logic [2:0] monSel;

  always_comb
  begin
    monSel      = ctl_reg[CTL_MON_LSB +: 3];
    monOut_next = 1'b0;
    monOe_next  = 1'b1;
    if (monSel == MON_TRISTATE)
      monOe_next = 1'b0;
    else if (monSel == MON_DIGITAL_LD)
      monOut_next = lockInt;
    else if (monSel == MON_FB_DIV)
      monOut_next = fbPulse_reg;
    else if (monSel == MON_HIGH)
      monOut_next = 1'b1;
    else if (monSel == MON_REF_DIV)
      monOut_next = refPulse_reg;
    else if (monSel == MON_ANALOG_LD)
      monOe_next = phaseWindow;
    else if (monSel == MON_SER_DATA)
      monOut_next = shift_reg[WORD_W-1];
    isolate_next = (band_next == BS_RUN);
    pd_next      = ~chipEnable;
    cpOe_next    = chipEnable && !ctl_reg[CTL_CPTRI_BIT] && !isolate_next;
    // supply stays off until digital lock when muting is asked for
    rfEn_next    = chipEnable && (!ctl_reg[CTL_MUTE_BIT] || lockInt);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      monOut_reg  <= 1'b0;
      monOe_reg   <= 1'b0;
      cpOe_reg    <= 1'b0;
      isolate_reg <= 1'b1;
      rfEn_reg    <= 1'b0;
      pd_reg      <= 1'b1;
    end
    else
    begin
      monOut_reg  <= monOut_next;
      monOe_reg   <= monOe_next;
      cpOe_reg    <= cpOe_next;
      isolate_reg <= isolate_next;
      rfEn_reg    <= rfEn_next;
      pd_reg      <= pd_next;
    end
  end

  assign monitorOut        = monOut_reg;
  assign monitorOe         = monOe_reg;
  assign digitalLock       = lockInt;
  assign prescalerSel      = ctl_reg[CTL_PRESC_LSB +: 2];
  assign modulusCtrl       = modulus_reg;
  assign halveOutput       = fbLatch_reg[FB_HALVE_BIT];
  assign chargePumpOe      = cpOe_reg;
  assign tuneIsolate       = isolate_reg;
  assign rfStageEnable     = rfEn_reg;
  assign powerDown         = pd_reg;
  assign antibacklashWidth = refLatch_reg[REF_BKLASH_LSB +: 2];
  assign outputLevel       = ctl_reg[CTL_LEVEL_LSB +: 2];

  shift_in_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    serEdge |=> shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(serData)})
    else $error("shift register did not take the serial bit");

  latch_ctl_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (strobeEdge && shift_reg[1:0] == 2'h0) |=> ctl_reg == $past(shift_reg))
    else $error("control latch not loaded on strobe");

  latch_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (strobeEdge && shift_reg[1:0] == 2'h1) |=> $stable(ctl_reg) && $stable(fbLatch_reg)
      && refLatch_reg == $past(shift_reg))
    else $error("strobe disturbed an unselected latch");

  test_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (strobeEdge && shift_reg[1:0] == 2'h3) |=> $stable(ctl_reg) && $stable(refLatch_reg)
      && $stable(fbLatch_reg))
    else $error("test code changed a latch");

  band_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fbWrite |=> tuneIsolate ##1 tuneIsolate)
    else $error("feedback write did not start band select");

  band_isolate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tuneIsolate |-> !chargePumpOe)
    else $error("pump driven during band select");

  mute_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctl_reg[CTL_MUTE_BIT] && !lockInt) |=> !rfStageEnable)
    else $error("output stage on before lock");

  ce_down_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !chipEnable |=> powerDown && !chargePumpOe && !rfStageEnable)
    else $error("chip enable low did not power down");

endmodule // sspd_synth_core

// File: verif/sspd_host_model.sv
`timescale 1ns/100ps
module sspd_host_model
(
  input  wire logic core_clk,
  output logic      serClk,
  output logic      serData,
  output logic      latchStrobe
);
  initial
  begin
    serClk      = 1'b0;
    serData     = 1'b1;
    latchStrobe = 1'b0;
  end

  // two clocks per level so the core sees every edge
  task automatic hold2();
    repeat (2) @(negedge core_clk);
  endtask

  task automatic sendWord(input logic [23:0] word);
    for (int i = 23; i >= 0; i--)
    begin
      serClk  = 1'b0;
      serData = word[i];
      hold2();
      serClk = 1'b1;
      hold2();
    end
    serClk  = 1'b0;
    // data is stale now, so never leave the last bit standing
    serData = ~serData;
    hold2();
    latchStrobe = 1'b1;
    hold2();
    latchStrobe = 1'b0;
    hold2();
  endtask
endmodule // sspd_host_model

// File: verif/tb.sv
`timescale 1ns/100ps
module tb
  import sspd_pkg::*;
;
  localparam int FB_B = 15;
  localparam int FB_A = 2;

  logic       core_clk, rst_n, refIn, fbIn, chipEnable;
  logic       serClk, serData, latchStrobe;
  logic       monitorOut, monitorOe, digitalLock, modulusCtrl, halveOutput;
  logic       chargePumpOe, tuneIsolate, rfStageEnable, powerDown;
  logic [1:0] prescalerSel, antibacklashWidth, outputLevel;
  int         errCount, nTests;

  sspd_host_model host_u (.core_clk(core_clk), .serClk(serClk), .serData(serData),
                          .latchStrobe(latchStrobe));

  sspd_synth_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .serClk(serClk),
    .serData(serData), .latchStrobe(latchStrobe), .refIn(refIn), .fbIn(fbIn),
    .chipEnable(chipEnable), .monitorOut(monitorOut), .monitorOe(monitorOe),
    .digitalLock(digitalLock), .prescalerSel(prescalerSel), .modulusCtrl(modulusCtrl),
    .halveOutput(halveOutput), .chargePumpOe(chargePumpOe), .tuneIsolate(tuneIsolate),
    .rfStageEnable(rfStageEnable), .powerDown(powerDown),
    .antibacklashWidth(antibacklashWidth), .outputLevel(outputLevel));

  always #5 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input string name, input logic [1:0] seen, input logic [1:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [23:0] ctlWord(input logic [2:0] mon);
    return (24'(PRESC_16_17) << CTL_PRESC_LSB) | (24'h3 << CTL_LEVEL_LSB)
         | (24'h1 << CTL_MUTE_BIT) | (24'(mon) << CTL_MON_LSB) | 24'(SEL_CONTROL);
  endfunction

  // band clock divide kept low enough for the reference used here
  function automatic logic [23:0] refWord(input logic longCnt, input logic [1:0] bandDiv);
    return (24'(bandDiv) << REF_BANDDIV_LSB) | (24'(longCnt) << REF_LOCKCNT_BIT)
         | (24'h2 << REF_BKLASH_LSB) | (24'h1 << REF_R_LSB) | 24'(SEL_REFCNT);
  endfunction

  // 15 * 16 + 2 stays above the contiguity floor for 16/17
  function automatic logic [23:0] fbWord();
    return (24'h1 << FB_HALVE_BIT) | (24'(FB_B) << FB_B_LSB) | (24'(FB_A) << FB_A_LSB)
         | 24'(SEL_FBCNT);
  endfunction

  task automatic refRise();
    refIn = 1'b1;
    cyc(2);
    refIn = 1'b0;
    cyc(2);
  endtask

  // one phase detector cycle; feedback closes skew clocks after reference
  task automatic pair(input int skew, input bit doMod);
    if (doMod)
      chk("modulus start", {1'b0, modulusCtrl}, 2'h1);
    for (int k = 0; k < FB_B - 1; k++)
    begin
      fbIn = 1'b1;
      cyc(2);
      fbIn = 1'b0;
      cyc(2);
      if (doMod && k == FB_A - 1)
        chk("modulus swallowed", {1'b0, modulusCtrl}, 2'h0);
    end
    refIn = 1'b1;
    cyc(skew);
    fbIn = 1'b1;
    cyc(2);
    refIn = 1'b0;
    fbIn  = 1'b0;
    cyc(3);
  endtask

  task automatic resetScn();
    chk("tune isolate", {1'b0, tuneIsolate}, 2'h1);
    chk("lock", {1'b0, digitalLock}, 2'h0);
    chk("power down", {1'b0, powerDown}, 2'h0);
    chk("prescaler", prescalerSel, 2'h0);
  endtask

  task automatic progScn();
    host_u.sendWord(refWord(1'b0, 2'h0));
    chk("antibacklash", antibacklashWidth, 2'h2);
    chk("level kept", outputLevel, 2'h0);
    host_u.sendWord(ctlWord(MON_HIGH));
    chk("prescaler", prescalerSel, 2'h1);
    chk("level", outputLevel, 2'h3);
    chk("antibacklash kept", antibacklashWidth, 2'h2);
    chk("monitor high", {monitorOe, monitorOut}, 2'h3);
    chk("rf muted", {1'b0, rfStageEnable}, 2'h0);
    cyc(20);
    host_u.sendWord(fbWord());
    chk("halve", {1'b0, halveOutput}, 2'h1);
    chk("band restart", {tuneIsolate, chargePumpOe}, 2'h2);
    host_u.sendWord(24'hffffff);
    chk("test code dropped", prescalerSel, 2'h1);
    chk("test code dropped", antibacklashWidth, 2'h2);
  endtask

  task automatic bandScn();
    repeat (4) refRise();
    chk("band running", {tuneIsolate, chargePumpOe}, 2'h2);
    refRise();
    cyc(2);
    chk("band done", {tuneIsolate, chargePumpOe}, 2'h1);
    host_u.sendWord(ctlWord(MON_LOW));
    chk("monitor low", {monitorOe, monitorOut}, 2'h2);
    host_u.sendWord(ctlWord(MON_TRISTATE));
    chk("monitor off", {1'b0, monitorOe}, 2'h0);
  endtask

  task automatic lockScn();
    pair(5, 1'b0);
    pair(0, 1'b1);
    pair(0, 1'b0);
    chk("lock early", {1'b0, digitalLock}, 2'h0);
    pair(0, 1'b0);
    chk("lock short", {1'b0, digitalLock}, 2'h1);
    chk("rf unmuted", {1'b0, rfStageEnable}, 2'h1);
    host_u.sendWord(ctlWord(MON_DIGITAL_LD));
    chk("monitor lock", {monitorOe, monitorOut}, 2'h3);
    host_u.sendWord(ctlWord(MON_ANALOG_LD));
    chk("analog lock", {monitorOe, monitorOut}, 2'h0);
    pair(2, 1'b0);
    chk("lock mid error", {1'b0, digitalLock}, 2'h1);
    pair(5, 1'b0);
    chk("lock lost", {1'b0, digitalLock}, 2'h0);
    host_u.sendWord(refWord(1'b1, 2'h0));
    repeat (4) pair(0, 1'b0);
    chk("lock long early", {1'b0, digitalLock}, 2'h0);
    pair(0, 1'b0);
    chk("lock long", {1'b0, digitalLock}, 2'h1);
  endtask

  task automatic powerScn();
    chipEnable = 1'b0;
    cyc(3);
    chk("power down", {1'b0, powerDown}, 2'h1);
    chk("pump off", {chargePumpOe, rfStageEnable}, 2'h0);
    chipEnable = 1'b1;
    cyc(3);
    chk("power up", {1'b0, powerDown}, 2'h0);
  endtask

  // band clock halved, so band select needs ten reference edges
  task automatic divScn();
    host_u.sendWord(refWord(1'b0, 2'h1));
    host_u.sendWord(fbWord());
    repeat (9) refRise();
    chk("band div running", {tuneIsolate, chargePumpOe}, 2'h2);
    refRise();
    cyc(2);
    chk("band div done", {tuneIsolate, chargePumpOe}, 2'h1);
  endtask

  initial
  begin
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    refIn      = 1'b0;
    fbIn       = 1'b0;
    chipEnable = 1'b1;
    errCount   = 0;
    nTests     = 0;
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    resetScn();
    progScn();
    bandScn();
    lockScn();
    powerScn();
    divScn();
    wrapUp();
  end

  // whole run needs about two thousand clocks
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    $display("Error watchdog expected finish seen hang");
    wrapUp();
  end
endmodule // tb
